// ==== tcl_pkg.sv ====
// constants shared by the timer-two control logic
package tcl_pkg;
    // register indices; byte address on the bus is four times the index
    localparam logic [7:0] IDX_CONTROL = 8'hC8;
    localparam logic [7:0] IDX_MODE = 8'hC9;
    localparam logic [7:0] IDX_RELOAD_LOW = 8'hCA;
    localparam logic [7:0] IDX_RELOAD_HIGH = 8'hCB;
    localparam logic [7:0] IDX_COUNT_LOW = 8'hCC;
    localparam logic [7:0] IDX_COUNT_HIGH = 8'hCD;
    localparam logic [7:0] IDX_CLOCK_CONTROL = 8'hE0;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'hE1;
    localparam logic [7:0] IDX_IRQ_MASK = 8'hE2;

    // control register fields
    localparam int BIT_WRAP_FLAG = 7;
    localparam int BIT_EXT_EVENT_FLAG = 6;
    localparam int BIT_RX_BAUD_SOURCE = 5;
    localparam int BIT_TX_BAUD_SOURCE = 4;
    localparam int BIT_TRIGGER_PIN_ENABLE = 3;
    localparam int BIT_RUN_CONTROL = 2;
    localparam int BIT_COUNT_SOURCE_SELECT = 1;
    localparam int BIT_CAPTURE_RELOAD_SELECT = 0;

    // mode register fields
    localparam int BIT_CAPTURE_RESET = 3;
    localparam int BIT_DOWN_COUNT_ENABLE = 0;

    // clock control field
    localparam int BIT_TICK_RATE_SELECT = 5;

    // interrupt status and mask fields
    localparam int BIT_IRQ_WRAP = 0;
    localparam int BIT_IRQ_EXT = 1;

    // reset values and the top value of the count
    localparam logic [7:0] RESET_CONTROL = 8'h00;
    localparam logic [15:0] RESET_COUNT = 16'h0000;
    localparam logic [15:0] RESET_RELOAD = 16'h0000;
    localparam logic [15:0] COUNT_TOP = 16'hFFFF;

    // tick divisors in core clock cycles
    localparam logic [3:0] DIV_SLOW = 4'hC;
    localparam logic [3:0] DIV_FAST = 4'h4;
    localparam logic [3:0] DIV_BAUD = 4'h2;
endpackage

// ==== tcl_edge_sync.sv ====
// two-flop synchroniser and falling-edge detector for the trigger pin
`timescale 1ns/1ps
module tcl_edge_sync (
    input wire logic clock,
    input wire logic rst,
    input wire logic pinIn,
    output logic pinLevel,
    output logic pinFall
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
        logic fall;
    } tcl_sync_state_type;

    tcl_sync_state_type s;
    tcl_sync_state_type next_s;

    always_comb begin
        next_s = s;
        next_s.meta = pinIn;
        next_s.sync = s.meta;
        next_s.prev = s.sync;
        next_s.fall = s.prev & ~s.sync;
    end

    // pin idles high after reset so no false edge is seen
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s <= '{meta: 1'b1, sync: 1'b1, prev: 1'b1, fall: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign pinLevel = s.sync;
    assign pinFall = s.fall;
endmodule // tcl_edge_sync

// ==== tcl_timer.sv ====
// timer-two control logic with classic wishbone register slave
// Notes on behaviour
// - overflow of the 16-bit count sets the wrap flag, control bit 7.
// - counting down, reaching the reload value also sets the wrap flag.
// - hardware sets wrap flag only with both baud sources zero; software always.
// - pin falling edge or overflow/underflow sets external-event flag per select bits.
// - event flag stays until software clears; pin or software set requests interrupt.
// - bit 5 picks receive baud source; one forces baud generator mode.
// - bit 4 picks transmit baud source; one forces baud generator mode.
// - pin enable bit 3 lets falling edges capture or reload, outside baud mode and up/down mode.
// - run bit 2 starts and stops counting; stopped count holds except on a pin-edge reload or capture reset.
// - count source bit 1 selects internal ticks or trigger-pin falling edges.
// - baud generator mode applies regardless of count source select.
// - capture/reload bit 0 selects reload or capture on overflow or pin edge.
// - in baud mode the select bit is ignored and overflow always reloads.
// - down-count enable lets the count run up or down in auto-reload mode.
// - capture stores count bytes in reload registers; reload mode loads from them.
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
module tcl_timer (
    input wire logic clock,
    input wire logic rst,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [31:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic extTriggerPin,
    output logic rxBaudTick,
    output logic txBaudTick,
    output logic timerRequest,
    output logic irq
);
    typedef struct packed {
        logic [7:0] control;
        logic captureReset;
        logic downCountEnable;
        logic tickRateSelect;
        logic [15:0] count;
        logic [15:0] reload;
        logic [3:0] divCount;
        logic [1:0] irqStatus;
        logic [1:0] irqMask;
        logic ack;
        logic [7:0] readData;
        logic rxTick;
        logic txTick;
    } tcl_state_type;

    tcl_state_type s;
    tcl_state_type next_s;

    logic pinLevel;
    logic pinFall;

    tcl_edge_sync u_edge_sync (
        .clock(clock),
        .rst(rst),
        .pinIn(extTriggerPin),
        .pinLevel(pinLevel),
        .pinFall(pinFall)
    );

    // true when the bus address selects the given register index
    function automatic logic regHit(input logic [31:0] adr, input logic [7:0] idx);
        regHit = (adr[31:10] == 22'h000000) && (adr[9:2] == idx) && (adr[1:0] == 2'h0);
    endfunction

    // read mux over the register map; unmapped indices read zero
    function automatic logic [7:0] regRead(input logic [31:0] adr, input tcl_state_type st);
        regRead = 8'h00;
        if (regHit(adr, tcl_pkg::IDX_CONTROL)) begin
            regRead = st.control;
        end else if (regHit(adr, tcl_pkg::IDX_MODE)) begin
            regRead[tcl_pkg::BIT_CAPTURE_RESET] = st.captureReset;
            regRead[tcl_pkg::BIT_DOWN_COUNT_ENABLE] = st.downCountEnable;
        end else if (regHit(adr, tcl_pkg::IDX_RELOAD_LOW)) begin
            regRead = st.reload[7:0];
        end else if (regHit(adr, tcl_pkg::IDX_RELOAD_HIGH)) begin
            regRead = st.reload[15:8];
        end else if (regHit(adr, tcl_pkg::IDX_COUNT_LOW)) begin
            regRead = st.count[7:0];
        end else if (regHit(adr, tcl_pkg::IDX_COUNT_HIGH)) begin
            regRead = st.count[15:8];
        end else if (regHit(adr, tcl_pkg::IDX_CLOCK_CONTROL)) begin
            regRead[tcl_pkg::BIT_TICK_RATE_SELECT] = st.tickRateSelect;
        end else if (regHit(adr, tcl_pkg::IDX_IRQ_STATUS)) begin
            regRead[1:0] = st.irqStatus;
        end else if (regHit(adr, tcl_pkg::IDX_IRQ_MASK)) begin
            regRead[1:0] = st.irqMask;
        end
    endfunction

    always_comb begin
        logic access;
        logic wrEn;
        logic rdEn;
        logic baudMode;
        logic upDownMode;
        logic countUp;
        logic [3:0] divisor;
        logic tickPulse;
        logic countEn;
        logic pinAction;
        logic overflow;
        logic hwWrap;
        logic hwExt;
        logic swExtSet;
        logic [1:0] events;
        access = 1'b0;
        wrEn = 1'b0;
        rdEn = 1'b0;
        baudMode = 1'b0;
        upDownMode = 1'b0;
        countUp = 1'b1;
        divisor = tcl_pkg::DIV_SLOW;
        tickPulse = 1'b0;
        countEn = 1'b0;
        pinAction = 1'b0;
        overflow = 1'b0;
        hwWrap = 1'b0;
        hwExt = 1'b0;
        swExtSet = 1'b0;
        events = 2'h0;
        next_s = s;

        // single-cycle classic answer: ack one cycle after the strobe, dropped the next
        access = cyc_i & stb_i & ~s.ack;
        wrEn = access & we_i & sel_i[0];
        rdEn = access & ~we_i;
        next_s.ack = access;

        baudMode = s.control[tcl_pkg::BIT_RX_BAUD_SOURCE] | s.control[tcl_pkg::BIT_TX_BAUD_SOURCE];
        upDownMode = s.downCountEnable & ~s.control[tcl_pkg::BIT_CAPTURE_RELOAD_SELECT] & ~baudMode;
        // count direction follows the pin level in up/down mode, low counts down
        countUp = upDownMode ? pinLevel : 1'b1;

        if (baudMode) begin
            divisor = tcl_pkg::DIV_BAUD;
        end else if (s.tickRateSelect) begin
            divisor = tcl_pkg::DIV_FAST;
        end else begin
            divisor = tcl_pkg::DIV_SLOW;
        end
        // divider restarts whenever the selected rate changes past its limit
        tickPulse = (s.divCount >= divisor - 4'h1);
        next_s.divCount = tickPulse ? 4'h0 : s.divCount + 4'h1;

        if (s.control[tcl_pkg::BIT_RUN_CONTROL]) begin
            if (baudMode || !s.control[tcl_pkg::BIT_COUNT_SOURCE_SELECT]) begin
                countEn = tickPulse;
            end else begin
                countEn = pinFall;
            end
        end

        if (countEn) begin
            if (countUp) begin
                if (s.count == tcl_pkg::COUNT_TOP) begin
                    overflow = 1'b1;
                end else begin
                    next_s.count = s.count + 16'h0001;
                end
            end else begin
                if (s.count == s.reload) begin
                    overflow = 1'b1;
                end else begin
                    next_s.count = s.count - 16'h0001;
                end
            end
        end

        if (overflow) begin
            if (baudMode) begin
                next_s.count = s.reload;
            end else if (s.control[tcl_pkg::BIT_CAPTURE_RELOAD_SELECT]) begin
                next_s.count = 16'h0000;
            end else if (countUp) begin
                next_s.count = s.reload;
            end else begin
                next_s.count = tcl_pkg::COUNT_TOP;
            end
        end
        hwWrap = overflow & ~baudMode;
        hwExt = overflow & upDownMode;

        // pin edges neither capture nor reload while generating baud clocks
        pinAction = pinFall & s.control[tcl_pkg::BIT_TRIGGER_PIN_ENABLE] & ~baudMode;
        if (pinAction && !upDownMode) begin
            if (s.control[tcl_pkg::BIT_CAPTURE_RELOAD_SELECT]) begin
                next_s.reload = s.count;
                if (s.captureReset) begin
                    next_s.count = 16'h0000;
                end
            end else begin
                next_s.count = s.reload;
            end
            hwExt = 1'b1;
        end

        next_s.rxTick = overflow & s.control[tcl_pkg::BIT_RX_BAUD_SOURCE];
        next_s.txTick = overflow & s.control[tcl_pkg::BIT_TX_BAUD_SOURCE];

        // software writes win over counting, flag sets by hardware win over software
        if (wrEn) begin
            if (regHit(adr_i, tcl_pkg::IDX_CONTROL)) begin
                next_s.control = dat_i[7:0];
                swExtSet = dat_i[tcl_pkg::BIT_EXT_EVENT_FLAG] & ~s.control[tcl_pkg::BIT_EXT_EVENT_FLAG];
            end
            if (regHit(adr_i, tcl_pkg::IDX_MODE)) begin
                next_s.captureReset = dat_i[tcl_pkg::BIT_CAPTURE_RESET];
                next_s.downCountEnable = dat_i[tcl_pkg::BIT_DOWN_COUNT_ENABLE];
            end
            if (regHit(adr_i, tcl_pkg::IDX_RELOAD_LOW)) begin
                next_s.reload[7:0] = dat_i[7:0];
            end
            if (regHit(adr_i, tcl_pkg::IDX_RELOAD_HIGH)) begin
                next_s.reload[15:8] = dat_i[7:0];
            end
            if (regHit(adr_i, tcl_pkg::IDX_COUNT_LOW)) begin
                next_s.count[7:0] = dat_i[7:0];
            end
            if (regHit(adr_i, tcl_pkg::IDX_COUNT_HIGH)) begin
                next_s.count[15:8] = dat_i[7:0];
            end
            if (regHit(adr_i, tcl_pkg::IDX_CLOCK_CONTROL)) begin
                next_s.tickRateSelect = dat_i[tcl_pkg::BIT_TICK_RATE_SELECT];
            end
            if (regHit(adr_i, tcl_pkg::IDX_IRQ_MASK)) begin
                next_s.irqMask = dat_i[1:0];
            end
        end
        if (hwWrap) begin
            next_s.control[tcl_pkg::BIT_WRAP_FLAG] = 1'b1;
        end
        if (hwExt) begin
            next_s.control[tcl_pkg::BIT_EXT_EVENT_FLAG] = 1'b1;
        end

        events[tcl_pkg::BIT_IRQ_WRAP] = hwWrap;
        events[tcl_pkg::BIT_IRQ_EXT] = hwExt | swExtSet;
        if (rdEn && regHit(adr_i, tcl_pkg::IDX_IRQ_STATUS)) begin
            next_s.irqStatus = events;
        end else begin
            next_s.irqStatus = s.irqStatus | events;
        end

        next_s.readData = rdEn ? regRead(adr_i, s) : 8'h00;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s <= '{control: tcl_pkg::RESET_CONTROL, captureReset: 1'b0, downCountEnable: 1'b0,
                   tickRateSelect: 1'b0, count: tcl_pkg::RESET_COUNT, reload: tcl_pkg::RESET_RELOAD,
                   divCount: 4'h0, irqStatus: 2'h0, irqMask: 2'h0, ack: 1'b0, readData: 8'h00,
                   rxTick: 1'b0, txTick: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign ack_o = s.ack;
    assign dat_o = {24'h000000, s.readData};
    assign rxBaudTick = s.rxTick;
    assign txBaudTick = s.txTick;
    // classic level request straight from the two flags
    assign timerRequest = s.control[tcl_pkg::BIT_WRAP_FLAG] | s.control[tcl_pkg::BIT_EXT_EVENT_FLAG];
    assign irq = |(s.irqStatus & s.irqMask);
endmodule // tcl_timer

// ==== tcl_timer_sva.sv ====
// port-level assertions for the timer-two control logic
`timescale 1ns/1ps
module tcl_timer_sva (
    input wire logic clock,
    input wire logic rst,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [31:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic extTriggerPin,
    input wire logic rxBaudTick,
    input wire logic txBaudTick,
    input wire logic timerRequest,
    input wire logic irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic wrCtl;
    logic wrMask;
    assign wrCtl = ack_o && cyc_i && stb_i && we_i && sel_i[0] && adr_i == 32'h320;
    assign wrMask = ack_o && cyc_i && stb_i && we_i && sel_i[0] && adr_i == 32'h388;
    property p_req_ack; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
    a_req_ack: assert property (p_req_ack) else $error("request not answered next cycle");
    property p_ack_pulse; ack_o |=> !ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held over one cycle");
    property p_ack_cause; ack_o |-> $past(cyc_i && stb_i); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_dat_idle; !ack_o |-> dat_o == 32'h0; endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack cycle");
    property p_dat_upper; ack_o |-> dat_o[31:8] == 24'h0; endproperty
    a_dat_upper: assert property (p_dat_upper) else $error("upper read data not zero");
    property p_sw_flag; wrCtl && dat_i[7] |-> ##[0:1] timerRequest; endproperty
    a_sw_flag: assert property (p_sw_flag) else $error("software set flag not seen");
    property p_irq_off; wrMask && dat_i[1:0] == 2'b00 |=> !irq [*2]; endproperty
    a_irq_off: assert property (p_irq_off) else $error("masked interrupt still high");
    property p_rx_pulse; rxBaudTick |=> !rxBaudTick; endproperty
    a_rx_pulse: assert property (p_rx_pulse) else $error("receive tick too long");
    property p_tx_pulse; $rose(txBaudTick) |=> $fell(txBaudTick); endproperty
    a_tx_pulse: assert property (p_tx_pulse) else $error("transmit tick too long");
    c_irq: cover property (irq);
    c_rx: cover property (rxBaudTick && txBaudTick);
    c_req: cover property (timerRequest && wrCtl);
endmodule // tcl_timer_sva

bind tcl_timer tcl_timer_sva u_sva (.clock(clock), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .extTriggerPin(extTriggerPin),
    .rxBaudTick(rxBaudTick), .txBaudTick(txBaudTick), .timerRequest(timerRequest), .irq(irq));

// ==== tcl_pin_model.sv ====
// trigger pin source and serial-port baud tick counter
`timescale 1ns/1ps
module tcl_pin_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic fallReq,
    input wire logic holdLow,
    input wire logic rxTick,
    input wire logic txTick,
    output logic pin,
    output logic [7:0] rxCount,
    output logic [7:0] txCount
);
    logic [2:0] lowLeft;
    // idles high as if pulled up; six low cycles outlast the two-flop synchroniser
    assign pin = !(holdLow || lowLeft != 3'h0);
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            lowLeft <= 3'h0;
            rxCount <= 8'h00;
            txCount <= 8'h00;
        end else begin
            if (fallReq) begin
                lowLeft <= 3'h6;
            end else if (lowLeft != 3'h0) begin
                lowLeft <= lowLeft - 3'h1;
            end
            rxCount <= rxCount + {7'h0, rxTick};
            txCount <= txCount + {7'h0, txTick};
        end
    end
endmodule // tcl_pin_model

// ==== test_timer2_control_logic.sv ====
// self-checking bench for the timer-two control logic
`timescale 1ns/1ps
module test_timer2_control_logic;
    localparam logic [31:0] CTL = 32'h320, MODE = 32'h324, RLO = 32'h328, RHI = 32'h32C;
    localparam logic [31:0] CLO = 32'h330, CHI = 32'h334, CLK = 32'h380, STA = 32'h384, MSK = 32'h388;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [31:0] adr = 32'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic fallReq = 1'b0;
    logic holdLow = 1'b0;
    logic [31:0] rdat;
    logic ack, pin, rxTick, txTick, timerRequest, irq;
    logic [7:0] rxCount, txCount, q, held;
    int mismatches = 0;
    int checks = 0;
    always #2.5 clock = ~clock;
    tcl_timer u_dut (.clock(clock), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
        .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .extTriggerPin(pin), .rxBaudTick(rxTick), .txBaudTick(txTick),
        .timerRequest(timerRequest), .irq(irq));
    tcl_pin_model u_pin (.clock(clock), .rst(rst), .fallReq(fallReq), .holdLow(holdLow), .rxTick(rxTick),
        .txTick(txTick), .pin(pin), .rxCount(rxCount), .txCount(txCount));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wb(input logic w, input logic [31:0] a, input logic [7:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'h1;
        wdat <= {24'h0, d};
        do begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && n < 20);
        chk("ack", {7'h0, ack}, 8'h01);
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        wb(1'b1, a, d);
    endtask
    task automatic rd(input string nm, input logic [31:0] a, input logic [7:0] exp);
        wb(1'b0, a, 8'h00);
        chk(nm, q, exp);
    endtask
    task automatic fall();
        fallReq <= 1'b1;
        @(posedge clock);
        fallReq <= 1'b0;
        repeat (14) @(posedge clock);
    endtask
    initial begin
        #20000;
        mismatches++;
        end_of_test();
    end
    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd("control", CTL, 8'h00);
        rd("count high", CHI, 8'h00);
        rd("unmapped", 32'h3FC, 8'h00);
        wr(MSK, 8'h03);
        wr(CTL, 8'hC0);
        rd("control", CTL, 8'hC0);
        chk("irq", {7'h0, irq}, 8'h01);
        chk("request", {7'h0, timerRequest}, 8'h01);
        wr(CTL, 8'h00);
        rd("control", CTL, 8'h00);
        rd("irq status", STA, 8'h02);
        wr(CLK, 8'h20);
        wr(RLO, 8'h34);
        wr(RHI, 8'h12);
        wr(CLO, 8'hFE);
        wr(CHI, 8'hFF);
        wr(CTL, 8'h04);
        repeat (20) @(posedge clock);
        rd("control", CTL, 8'h84);
        rd("count high", CHI, 8'h12);
        chk("irq", {7'h0, irq}, 8'h01);
        rd("irq status", STA, 8'h01);
        chk("irq", {7'h0, irq}, 8'h00);
        wr(CTL, 8'h00);
        wb(1'b0, CLO, 8'h00);
        held = q;
        repeat (30) @(posedge clock);
        rd("count low", CLO, held);
        wr(CLO, 8'h78);
        wr(CHI, 8'h56);
        wr(CTL, 8'h09);
        fall();
        rd("control", CTL, 8'h49);
        rd("reload low", RLO, 8'h78);
        rd("reload high", RHI, 8'h56);
        rd("irq status", STA, 8'h02);
        // capture with the reset-on-capture mode bit: reload takes the count, count clears
        wr(MODE, 8'h08);
        wr(CLO, 8'h9A);
        fall();
        rd("mode", MODE, 8'h08);
        rd("reload low", RLO, 8'h9A);
        rd("count high", CHI, 8'h00);
        rd("irq status", STA, 8'h02);
        wr(CTL, 8'h01);
        fall();
        rd("control", CTL, 8'h01);
        chk("request", {7'h0, timerRequest}, 8'h00);
        wr(CLO, 8'h00);
        wr(CTL, 8'h06);
        repeat (3) fall();
        rd("count low", CLO, 8'h03);
        wr(RLO, 8'hFE);
        wr(RHI, 8'hFF);
        wr(CLO, 8'hFE);
        wr(CHI, 8'hFF);
        wr(CTL, 8'h37);
        repeat (40) @(posedge clock);
        rd("control", CTL, 8'h37);
        rd("count high", CHI, 8'hFF);
        chk("rx ticks", {7'h0, rxCount > 8'h00}, 8'h01);
        chk("tx ticks", {7'h0, txCount > 8'h00}, 8'h01);
        rd("irq status", STA, 8'h00);
        wr(CTL, 8'h00);
        wr(RLO, 8'h34);
        wr(RHI, 8'h12);
        wr(CLO, 8'h36);
        wr(CHI, 8'h12);
        wr(MODE, 8'h01);
        holdLow <= 1'b1;
        repeat (6) @(posedge clock);
        wr(CTL, 8'h04);
        repeat (30) @(posedge clock);
        rd("control", CTL, 8'hC4);
        rd("count high", CHI, 8'hFF);
        wr(MSK, 8'h00);
        chk("irq", {7'h0, irq}, 8'h00);
        // second reset in mid-run, then the slow tick rate that reset selects
        holdLow <= 1'b0;
        rst <= 1'b1;
        repeat (3) @(posedge clock);
        chk("request in reset", {7'h0, timerRequest}, 8'h00);
        chk("irq in reset", {7'h0, irq}, 8'h00);
        rst <= 1'b0;
        @(posedge clock);
        rd("control", CTL, 8'h00);
        rd("count high", CHI, 8'h00);
        // run exactly 48 cycles between the two control writes: four slow ticks whatever the divider phase
        wr(CTL, 8'h04);
        repeat (45) @(posedge clock);
        wr(CTL, 8'h00);
        rd("count low", CLO, 8'h04);
        end_of_test();
    end
endmodule // test_timer2_control_logic
